// *** rtl/cspc_pkg.sv ***
// constants and types shared by the clock source and pll control block
// What this block does
// - clock enables of unused domains stop under the chosen sleep mode
// - core state stays frozen whenever the core clock enable is low
// - peripheral clock drives timers, serial unit, interrupts; async interrupts still seen
// - program memory clock runs whenever the core clock runs
// - converter clock keeps running in noise-reduction sleep while core and peripheral clocks stop
// - pll multiplies the 1 MHz reference by 64 for the fast peripheral clock
// - second timer clocks from the fast clock or a prescaled copy of it
// - reference above 1 MHz saturates the output at 70 MHz and drops lock
// - pll runs only while the enable bit is set or its fuse is 0
// - lock flag sets once the pll has locked to its reference
// - power-down and standby switch off the rc oscillator and the pll
// - fuse 1: codes 1111-1010 crystal, 1001 low-frequency crystal
// - fuse 1: 1000-0101 external rc, 0100-0001 internal rc, 0000 external clock
// - fuse 0 with code 0001 selects the pll output as system clock
// - oscillator pins are clock or general io according to the source
// - every fuse reads 1 as unprogrammed and 0 as programmed
// - wake from power-down counts source cycles before execution starts
// - start from reset adds a watchdog-oscillator delay before running
// - reset delay counts 4096 or 65536 watchdog cycles per start-up select
// - delivered fuses: select 0001, start-up 10, pll fuse unprogrammed
package cspc_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int LOCK_TIME_US = 100;
   localparam int LOCK_CYCLES = (LOCK_TIME_US * (CLK_HZ / 1_000_000));
   localparam int WDT_SHORT = 4096;
   localparam int WDT_LONG = 65536;
   localparam int PLL_MULT = 64;
   localparam int PLL_SAT_MHZ = 70;
   localparam int REF_NOM_KHZ = 1000;
   localparam int OSC_SHORT = 258;
   localparam int OSC_MID = 1024;
   localparam int OSC_LONG = 16384;
   localparam int OSC_LF = 32768;
   localparam int OSC_RC = 18;
   localparam int OSC_RC_FAST = 6;
   localparam int OSC_INT = 6;
   // ----------------------------------------------------------------
   // fuses and delivered values
   // ----------------------------------------------------------------
   localparam logic [3:0] CLOCK_SELECT_FIELD_DEFAULT = 4'h1;
   localparam logic [1:0] SUT_DEFAULT = 2'h2;
   localparam logic PLL_CLOCK_FUSE_DEFAULT = 1'b1;
   localparam logic FUSE_PROG = 1'b0;
   localparam logic [3:0] SEL_EXTCLK = 4'h0;
   localparam logic [3:0] SEL_INT_LO = 4'h1;
   localparam logic [3:0] SEL_INT_HI = 4'h4;
   localparam logic [3:0] SEL_ERC_HI = 4'h8;
   localparam logic [3:0] SEL_LF = 4'h9;
   localparam logic [3:0] SEL_PLL = 4'h1;
   // ----------------------------------------------------------------
   // wishbone register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADR_PLLCS = 4'h0;
   localparam logic [3:0] ADR_SLEEP = 4'h4;
   localparam logic [3:0] ADR_TMR = 4'h8;
   localparam logic [3:0] ADR_STAT = 4'hC;
   localparam int PLL_ENABLE_BIT_BIT = 1;
   localparam int LOCK_BIT = 0;
   localparam int TPRE_W = 4;
   localparam int CNT_W = 17;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CSPC_SRC_EXTCLK = 3'h0, CSPC_SRC_INTRC = 3'h1, CSPC_SRC_EXTRC = 3'h2,
      CSPC_SRC_LFXT = 3'h3, CSPC_SRC_XTAL = 3'h4, CSPC_SRC_PLL = 3'h5
   } cspc_src_t;
   typedef enum logic [1:0] {
      CSPC_SLP_ACTIVE = 2'h0, CSPC_SLP_IDLE = 2'h1, CSPC_SLP_NOISE = 2'h2, CSPC_SLP_DOWN = 2'h3
   } cspc_sleep_t;
   typedef enum logic [1:0] {
      CSPC_ST_RESET = 2'h0, CSPC_ST_OSC = 2'h1, CSPC_ST_RUN = 2'h2, CSPC_ST_SLEEP = 2'h3
   } cspc_state_t;
   typedef struct packed {
      cspc_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [15:0] lock_cnt;
      logic pll_en;
      logic lock;
      cspc_sleep_t sleep;
      logic standby;
      logic [TPRE_W-1:0] tmr_pre;
      logic tmr_fast;
      logic [TPRE_W-1:0] pre_cnt;
      logic tmr_tick;
      logic ack;
      logic [31:0] dat;
      logic [1:0] wdt_s;
      logic wdt_prev;
      logic [1:0] osc_s;
      logic osc_prev;
   } cspc_state_s_t;
endpackage : cspc_pkg

// *** rtl/cspc_top.sv ***
// clock source selection, domain gating, pll control and start-up timing
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module cspc_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // configuration fuses, 0 means programmed
   input wire logic [3:0] clock_select_field_i,
   input wire logic [1:0] startup_time_select_i,
   input wire logic pll_clock_fuse_i,
   // oscillator ticks and the pll reference over-range flag from outside
   input wire logic watchdog_oscillator_i,
   input wire logic oscillator_input_pin_i,
   input wire logic pll_ref_over_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // clock domain enables
   output logic core_clock_o,
   output logic peripheral_clock_o,
   output logic program_memory_clock_o,
   output logic converter_clock_o,
   output logic fast_peripheral_clock_o,
   output logic timer2_clock_o,
   output logic async_irq_detect_o,
   // oscillator and pll control
   output logic rc_osc_on_o,
   output logic pll_on_o,
   output logic [2:0] clock_source_o,
   // shared pins: output enable low means the block owns the pin as clock
   output logic shared_pin_four_oe_n_o,
   output logic shared_pin_five_oe_n_o
);
   import cspc_pkg::*;

   // ----------------------------------------------------------------
   // source decode
   // ----------------------------------------------------------------
   // the fuse value 0 means programmed
   function automatic cspc_src_t decode_src(input logic [3:0] sel, input logic pll_clock_fuse);
      cspc_src_t s;
      s = CSPC_SRC_INTRC;
      if (pll_clock_fuse == FUSE_PROG) begin
         s = (sel == SEL_PLL) ? CSPC_SRC_PLL : CSPC_SRC_INTRC;
      end else if (sel > SEL_LF) begin
         s = CSPC_SRC_XTAL;
      end else if (sel == SEL_LF) begin
         s = CSPC_SRC_LFXT;
      end else if (sel > SEL_INT_HI) begin
         s = CSPC_SRC_EXTRC;
      end else if (sel >= SEL_INT_LO) begin
         s = CSPC_SRC_INTRC;
      end else begin
         s = CSPC_SRC_EXTCLK;
      end
      return s;
   endfunction : decode_src

   // start-up source cycle count for wake from power-down
   function automatic logic [CNT_W-1:0] osc_count(input cspc_src_t s, input logic c0, input logic [1:0] startup_time_select);
      int n;
      n = OSC_INT;
      case (s)
         CSPC_SRC_XTAL: n = c0 ? OSC_LONG : ((startup_time_select[1]) ? OSC_MID : OSC_SHORT);
         CSPC_SRC_LFXT: n = (startup_time_select == 2'h2) ? OSC_LF : OSC_MID;
         CSPC_SRC_EXTRC: n = (startup_time_select == 2'h3) ? OSC_RC_FAST : OSC_RC;
         default: n = OSC_INT;
      endcase
      return CNT_W'(n);
   endfunction : osc_count

   cspc_state_s_t s_reg, s_next;
   cspc_src_t src;
   logic core_run;
   logic wdt_tick;
   logic osc_tick;
   logic pll_run;
   logic wb_req;
   logic off_mode;

   assign src = decode_src(clock_select_field_i, pll_clock_fuse_i);
   assign wdt_tick = s_reg.wdt_s[1] & ~s_reg.wdt_prev;
   assign osc_tick = s_reg.osc_s[1] & ~s_reg.osc_prev;
   assign off_mode = (s_reg.st == CSPC_ST_SLEEP) && (s_reg.sleep == CSPC_SLP_DOWN || s_reg.standby);
   // pll runs on enable bit or programmed fuse, never in deep sleep
   assign pll_run = (s_reg.pll_en || pll_clock_fuse_i == FUSE_PROG) && !off_mode;
   assign core_run = (s_reg.st == CSPC_ST_RUN);
   assign wb_req = wb_cyc_i & wb_stb_i & ~s_reg.ack;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // one comb pass covers sync, start-up, pll lock and bus
   always_comb begin
      s_next = s_reg;
      s_next.wdt_s = {s_reg.wdt_s[0], watchdog_oscillator_i};
      s_next.wdt_prev = s_reg.wdt_s[1];
      s_next.osc_s = {s_reg.osc_s[0], oscillator_input_pin_i};
      s_next.osc_prev = s_reg.osc_s[1];
      s_next.ack = 1'b0;
      s_next.tmr_tick = 1'b0;
      case (s_reg.st)
         CSPC_ST_RESET: begin
            // watchdog cycles give the real-time supply delay
            if (wdt_tick) begin
               s_next.cnt = s_reg.cnt + CNT_W'(1);
               if (s_reg.cnt == CNT_W'((startup_time_select_i[0] ? WDT_LONG : WDT_SHORT) - 1)) begin
                  s_next.st = CSPC_ST_OSC;
                  s_next.cnt = '0;
               end
            end
         end
         CSPC_ST_OSC: begin
            // count source cycles so the oscillator settles
            if (osc_tick || src == CSPC_SRC_INTRC || src == CSPC_SRC_PLL) begin
               s_next.cnt = s_reg.cnt + CNT_W'(1);
               if (s_reg.cnt == osc_count(src, clock_select_field_i[0], startup_time_select_i) - CNT_W'(1)) begin
                  s_next.st = CSPC_ST_RUN;
                  s_next.cnt = '0;
               end
            end
         end
         CSPC_ST_RUN: begin
            if (s_reg.sleep != CSPC_SLP_ACTIVE) begin
               s_next.st = CSPC_ST_SLEEP;
            end
         end
         CSPC_ST_SLEEP: begin
            // wake request clears the sleep field; deep sleep restarts oscillator
            if (s_reg.sleep == CSPC_SLP_ACTIVE) begin
               s_next.st = (s_reg.standby || off_mode) ? CSPC_ST_OSC : CSPC_ST_RUN;
               s_next.cnt = '0;
            end
         end
         default: s_next.st = CSPC_ST_RESET;
      endcase
      // lock after settling time, dropped on disable or over-range reference
      if (!pll_run || pll_ref_over_i) begin
         s_next.lock = 1'b0;
         s_next.lock_cnt = '0;
      end else if (s_reg.lock_cnt == 16'(LOCK_CYCLES - 1)) begin
         s_next.lock = 1'b1;
      end else begin
         s_next.lock_cnt = s_reg.lock_cnt + 16'h1;
      end
      // timer2 prescaler on the fast clock
      if (pll_run) begin
         s_next.pre_cnt = s_reg.pre_cnt + TPRE_W'(1);
         if (s_reg.pre_cnt == s_reg.tmr_pre) begin
            s_next.pre_cnt = '0;
            s_next.tmr_tick = 1'b1;
         end
      end
      // wishbone slave, one wait cycle, ack drops the cycle after
      if (wb_req) begin
         s_next.ack = 1'b1;
         s_next.dat = 32'h0;
         if (wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
               ADR_PLLCS: s_next.pll_en = wb_dat_i[PLL_ENABLE_BIT_BIT];
               ADR_SLEEP: begin
                  s_next.sleep = cspc_sleep_t'(wb_dat_i[1:0]);
                  s_next.standby = wb_dat_i[2];
                  // the deep mode is forgotten once cleared, so the restart is decided here
                  if (off_mode && wb_dat_i[2:0] == 3'h0) begin
                     s_next.st = CSPC_ST_OSC;
                     s_next.cnt = '0;
                  end
               end
               ADR_TMR: begin
                  s_next.tmr_pre = wb_dat_i[TPRE_W-1:0];
                  s_next.tmr_fast = wb_dat_i[TPRE_W];
               end
               default: s_next.ack = 1'b1;
            endcase
         end else if (!wb_we_i) begin
            case (wb_adr_i)
               ADR_PLLCS: s_next.dat = {30'h0, s_reg.pll_en, s_reg.lock};
               ADR_SLEEP: s_next.dat = {29'h0, s_reg.standby, s_reg.sleep};
               ADR_TMR: s_next.dat = {27'h0, s_reg.tmr_fast, s_reg.tmr_pre};
               ADR_STAT: s_next.dat = {27'h0, s_reg.st, src};
               default: s_next.dat = 32'h0;
            endcase
         end
      end
   end

   // state register, synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.st <= CSPC_ST_RESET;
         s_reg.sleep <= CSPC_SLP_ACTIVE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // gating: core frozen unless running, so core state cannot change
   assign core_clock_o = core_run;
   assign program_memory_clock_o = core_run;
   // idle field keeps peripherals, even with standby set; noise and power-down fields stop them
   assign peripheral_clock_o = core_run || (s_reg.st == CSPC_ST_SLEEP && s_reg.sleep == CSPC_SLP_IDLE);
   assign async_irq_detect_o = 1'b1;
   // converter runs through noise-reduction sleep
   assign converter_clock_o = core_run || (s_reg.st == CSPC_ST_SLEEP && s_reg.sleep != CSPC_SLP_DOWN);
   assign fast_peripheral_clock_o = pll_run;
   assign timer2_clock_o = s_reg.tmr_fast ? pll_run : s_reg.tmr_tick;
   assign rc_osc_on_o = !off_mode;
   assign pll_on_o = pll_run;
   assign clock_source_o = src;
   // pin ownership per source
   assign shared_pin_four_oe_n_o = !(src == CSPC_SRC_EXTCLK || src == CSPC_SRC_EXTRC ||
                                     src == CSPC_SRC_LFXT || src == CSPC_SRC_XTAL);
   assign shared_pin_five_oe_n_o = !(src == CSPC_SRC_LFXT || src == CSPC_SRC_XTAL);
   assign wb_ack_o = s_reg.ack;
   assign wb_dat_o = s_reg.dat;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_lock_clear: assert property (@(posedge clk_i) disable iff (rst_i) !pll_run |=> !s_reg.lock)
      else $error("lock flag set while pll disabled");
   a_pll_deep: assert property (@(posedge clk_i) disable iff (rst_i) off_mode |-> !pll_on_o && !rc_osc_on_o)
      else $error("pll or rc on in deep sleep");
   a_flash_core: assert property (@(posedge clk_i) disable iff (rst_i) core_clock_o |-> program_memory_clock_o)
      else $error("program memory clock off while core runs");
   a_conv_noise: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.st == CSPC_ST_SLEEP && s_reg.sleep == CSPC_SLP_NOISE) |-> converter_clock_o && !core_clock_o)
      else $error("converter clock wrong in noise sleep");
   a_pll_src: assert property (@(posedge clk_i) disable iff (rst_i)
      (pll_clock_fuse_i == FUSE_PROG && clock_select_field_i == SEL_PLL) |-> clock_source_o == CSPC_SRC_PLL)
      else $error("pll not chosen as source");
   a_xtal_sel: assert property (@(posedge clk_i) disable iff (rst_i)
      (pll_clock_fuse_i && clock_select_field_i > SEL_LF) |-> clock_source_o == CSPC_SRC_XTAL)
      else $error("crystal codes decoded wrong");
   a_erc_sel: assert property (@(posedge clk_i) disable iff (rst_i)
      (pll_clock_fuse_i && clock_select_field_i <= SEL_ERC_HI && clock_select_field_i > SEL_INT_HI)
      |-> clock_source_o == CSPC_SRC_EXTRC && !shared_pin_four_oe_n_o && shared_pin_five_oe_n_o)
      else $error("external rc decode or pins wrong");
   a_core_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.st == CSPC_ST_RESET) |-> !core_clock_o)
      else $error("core ran during reset delay");
   a_lock_rise: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(s_reg.lock) |-> $past(pll_run) && !$past(pll_ref_over_i))
      else $error("lock rose without running pll");
   a_en_pll: assert property (@(posedge clk_i) disable iff (rst_i)
      (!s_reg.pll_en && pll_clock_fuse_i) |-> !pll_on_o)
      else $error("pll ran without enable");
endmodule : cspc_top

// *** test/cspc_osc_model.sv ***
// oscillator network model: watchdog oscillator and external clock source
`timescale 1ns/10ps
module cspc_osc_model (
   // oscillator outputs
   output logic wdt_o,
   output logic osc_o
);
   // watchdog square wave, 200 ns period, phase unrelated to the system clock
   initial begin
      wdt_o = 1'b0;
      #13;
      forever #100 wdt_o = ~wdt_o;
   end
   // external source on the input pin runs free, a continuous clock has no frames
   initial begin
      osc_o = 1'b0;
      #7;
      forever #60 osc_o = ~osc_o;
   end
endmodule : cspc_osc_model

// *** test/test_clock_source_and_pll_control.sv ***
// self-checking bench for the clock source and pll control block
`timescale 1ns/10ps
module test_clock_source_and_pll_control;
   import cspc_pkg::*;
   // ----------------------------------------------------------------
   // signals and helpers
   // ----------------------------------------------------------------
   logic clk_i, rst_i, pll_clock_fuse_i, pll_ref_over_i, wdt, osc;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0] clock_select_field_i, wb_adr_i, wb_sel_i;
   logic [1:0] startup_time_select_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic core, periph, flash, conv, fast, tmr2, async_det, rc_on, pll_on, p4_n, p5_n;
   logic [2:0] src;
   logic [3:0] pre;
   int err_count, comparisons, n, s, seed;
   cspc_osc_model cspc_osc_model_inst (.wdt_o(wdt), .osc_o(osc));
   cspc_top cspc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .clock_select_field_i(clock_select_field_i),
      .startup_time_select_i(startup_time_select_i), .pll_clock_fuse_i(pll_clock_fuse_i),
      .watchdog_oscillator_i(wdt), .oscillator_input_pin_i(osc), .pll_ref_over_i(pll_ref_over_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_clock_o(core),
      .peripheral_clock_o(periph), .program_memory_clock_o(flash), .converter_clock_o(conv),
      .fast_peripheral_clock_o(fast), .timer2_clock_o(tmr2), .async_irq_detect_o(async_det),
      .rc_osc_on_o(rc_on), .pll_on_o(pll_on), .clock_source_o(src),
      .shared_pin_four_oe_n_o(p4_n), .shared_pin_five_oe_n_o(p5_n));
   // 20 MHz system clock
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic wrap_up();
      if (err_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : chk
   // classic single cycle; entered just after a rising edge, waits for ack
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d, output logic [31:0] rd);
      int k;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      k = 0;
      // ack is looked at mid-cycle where it has settled, taken at the next rising edge
      do begin
         @(negedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      if (k >= 20) begin
         err_count++;
         wrap_up();
      end
      rd = wb_dat_o;
      @(posedge clk_i);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   // bounded wait for a design output to reach a level
   task automatic wait_sig(ref logic sg, input logic v, input int lim, output int cnt);
      cnt = 0;
      while (sg !== v && cnt < lim) begin
         @(posedge clk_i);
         cnt++;
      end
      if (cnt >= lim) begin
         err_count++;
         wrap_up();
      end
   endtask : wait_sig
   // reference decode of the fuse settings
   function automatic int exp_src(input int f, input int c);
      if (f == 0) return 5;
      if (c >= 10) return 4;
      if (c == 9) return 3;
      if (c >= 5) return 2;
      if (c >= 1) return 1;
      return 0;
   endfunction : exp_src
   task automatic do_reset(input int f, input int c, input int cyc);
      rst_i <= 1'b1;
      pll_clock_fuse_i <= 1'(f);
      clock_select_field_i <= 4'(c);
      repeat (cyc) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask : do_reset
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      err_count = 0;
      comparisons = 0;
      seed = 29089;
      rst_i = 1'b1;
      pll_ref_over_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      pll_clock_fuse_i = PLL_CLOCK_FUSE_DEFAULT;
      clock_select_field_i = CLOCK_SELECT_FIELD_DEFAULT;
      startup_time_select_i = SUT_DEFAULT;
      repeat (16) @(posedge clk_i);
      chk("core in reset", 1'b0, core);
      chk("rc in reset", 1'b1, rc_on);
      // every clock select code plus the pll fuse case; short reset each time
      for (int i = 0; i < 17; i++) begin
         do_reset(i == 16 ? 0 : 1, i == 16 ? 1 : i, 2);
         s = exp_src(i == 16 ? 0 : 1, i == 16 ? 1 : i);
         wb(1'b0, ADR_STAT, 32'h0, q);
         chk("source field", 32'(s), {29'h0, q[2:0]});
         chk("state field", 32'h0, {30'h0, q[4:3]});
         chk("pin four", (s == 0 || s == 2 || s == 3 || s == 4) ? 0 : 1, {31'h0, p4_n});
         chk("pin five", (s == 3 || s == 4) ? 0 : 1, {31'h0, p5_n});
         if (i == 16) chk("pll by fuse", 1'b1, pll_on);
      end
      // delivered settings: 4096 watchdog edges, then the internal rc count
      do_reset(PLL_CLOCK_FUSE_DEFAULT, CLOCK_SELECT_FIELD_DEFAULT, 16);
      wait_sig(core, 1'b1, 20000, n);
      chk("startup min", 1'b1, 1'(n >= WDT_SHORT * 4 - 8));
      chk("startup max", 1'b1, 1'(n <= WDT_SHORT * 4 + 60));
      chk("flash with core", core, flash);
      wb(1'b0, ADR_STAT, 32'h0, q);
      chk("status run", 32'h11, q);
      wb(1'b0, 4'h2, 32'h0, q);
      chk("unmapped", 32'h0, q);
      // pll enable, lock, loss of lock on an over-range reference
      wb(1'b1, ADR_PLLCS, 32'h2, q);
      wb(1'b0, ADR_PLLCS, 32'h0, q);
      chk("lock early", 32'h2, q);
      chk("pll on", 1'b1, pll_on);
      chk("fast clock", 1'b1, fast);
      repeat (LOCK_CYCLES) @(posedge clk_i);
      wb(1'b0, ADR_PLLCS, 32'h0, q);
      chk("locked", 32'h3, q);
      pll_ref_over_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      wb(1'b0, ADR_PLLCS, 32'h0, q);
      chk("lock lost", 32'h2, q);
      chk("saturated runs", 1'b1, fast);
      pll_ref_over_i <= 1'b0;
      // second timer: prescaled pulse spacing, then the fast clock itself
      pre = 4'($random(seed));
      wb(1'b1, ADR_TMR, {28'h0, pre}, q);
      wait_sig(tmr2, 1'b1, 100, n);
      @(posedge clk_i);
      wait_sig(tmr2, 1'b1, 100, n);
      chk("timer spacing", 32'(pre) + 1, 32'(n + 1));
      wb(1'b1, ADR_TMR, 32'h10, q);
      repeat (2) @(posedge clk_i);
      chk("timer fast", 1'b1, tmr2);
      // sleep modes 1..3 and standby (5), each woken by mode 0
      for (int m = 1; m < 6; m = (m == 3) ? 5 : m + 1) begin
         wb(1'b1, ADR_SLEEP, 32'(m), q);
         repeat (2) @(posedge clk_i);
         chk("core asleep", 1'b0, core);
         chk("flash follows", core, flash);
         if (m == 1) chk("idle periph", 1'b1, periph);
         if (m == 2) chk("noise conv", 1'b1, conv);
         if (m == 2) chk("noise periph", 1'b0, periph);
         if (m == 2) chk("async detect", 1'b1, async_det);
         if (m >= 3) chk("rc off", 1'b0, rc_on);
         if (m >= 3) chk("pll off", 1'b0, pll_on);
         wb(1'b1, ADR_SLEEP, 32'h0, q);
         if (m == 3) chk("wake counted", 1'b0, core);
         wait_sig(core, 1'b1, 200, n);
      end
      wb(1'b1, ADR_PLLCS, 32'h0, q);
      wb(1'b0, ADR_PLLCS, 32'h0, q);
      chk("disabled", 32'h0, q);
      chk("pll stopped", 1'b0, pll_on);
      wrap_up();
   end
endmodule : test_clock_source_and_pll_control
